/* File: design/aet_cfg.svh */
`ifndef AET_CFG_SVH
`define AET_CFG_SVH
// Response codes
`define AET_RESP_OKAY     2'h0
`define AET_RESP_DECERR   2'h3
// Longest burst an AXI3 slave takes, in beats
`define AET_A3_MAX_BEATS  16
// Largest size code a lite slave takes (four bytes)
`define AET_LITE_MAX_SIZE 3'h2
// Protection bit that marks a non-secure access
`define AET_PROT_NS_BIT   1
// Incrementing burst type
`define AET_BURST_INCR    2'h1
`endif

/* File: design/aet_pkg.sv */
package aet_pkg;
  // Where a decoded transaction goes
  typedef enum logic [1:0] {TG_LITE, TG_A3, TG_TRAP} aet_tgt_e;
  // Write path sequence
  typedef enum logic [2:0] {WS_IDLE, WS_ADDR, WS_DATA, WS_RESP, WS_BOUT} aet_wst_e;
  // Read path sequence
  typedef enum logic [1:0] {RS_IDLE, RS_ADDR, RS_DATA} aet_rst_e;
endpackage : aet_pkg

/* File: design/aet_cmd_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface aet_cmd_if #(
  parameter int AW = 32,
  parameter int IW = 4
);
  logic [IW-1:0] id;
  logic [AW-1:0] addr;
  logic [7:0]    len;
  logic [2:0]    size;
  logic [1:0]    burst;
  logic          valid;
  logic          ready;
  logic          done;  // One split piece answered
  modport src (output id, addr, len, size, burst, valid, done, input ready);
  modport dst (input id, addr, len, size, burst, valid, done, output ready);
endinterface : aet_cmd_if
`default_nettype wire

/* File: design/aet_split.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aet_cfg.svh"
module aet_split #(
  parameter int AW     = 32,
  parameter int IW     = 4,
  parameter int MAXOUT = 4
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  aet_cmd_if.dst             c,
  output logic [IW-1:0]      o_id,
  output logic [AW-1:0]      o_addr,
  output logic [3:0]         o_len,
  output logic [2:0]         o_size,
  output logic [1:0]         o_burst,
  output logic               o_valid,
  input  wire logic          o_ready
);
  if (MAXOUT < 1 || MAXOUT > 200) begin : g_chk
    $error("MAXOUT out of range");
  end

  typedef struct packed {
    logic          busy;
    logic          splt;
    logic [IW-1:0] id;
    logic [AW-1:0] addr;
    logic [7:0]    rem;
    logic [2:0]    size;
    logic [1:0]    burst;
    logic [7:0]    outst;
  } aet_split_s;

  localparam logic [7:0] MAXLEN = 8'(`AET_A3_MAX_BEATS - 1);
  aet_split_s st_r, st_nxt;
  logic       need, o_hs;

  // Accept rules: many plain commands, or one splitting command alone
  assign need    = c.len > MAXLEN;
  assign c.ready = !st_r.busy && !(st_r.splt && st_r.outst != 8'h00) &&
                   (need ? st_r.outst == 8'h00 : st_r.outst < 8'(MAXOUT));
  assign o_hs    = o_valid && o_ready;
  assign o_valid = st_r.busy;
  assign o_id    = st_r.id;
  assign o_addr  = st_r.addr;
  assign o_size  = st_r.size;
  assign o_burst = st_r.burst;
  assign o_len   = (st_r.rem > MAXLEN) ? MAXLEN[3:0] : st_r.rem[3:0];

  // Next state: carve 16-beat pieces, count pieces awaiting answers
  always_comb begin
    st_nxt = st_r;
    if (c.valid && c.ready) begin
      st_nxt.busy  = 1'b1;
      st_nxt.splt  = need;
      st_nxt.id    = c.id;
      st_nxt.addr  = c.addr;
      st_nxt.rem   = c.len;
      st_nxt.size  = c.size;
      st_nxt.burst = c.burst;
    end
    if (o_hs) begin
      if (st_r.rem > MAXLEN) begin
        st_nxt.rem = st_r.rem - 8'(`AET_A3_MAX_BEATS);
        if (st_r.burst == `AET_BURST_INCR) begin
          st_nxt.addr = st_r.addr + (AW'(`AET_A3_MAX_BEATS) << st_r.size);
        end
      end else begin
        st_nxt.busy = 1'b0;
      end
    end
    st_nxt.outst = st_r.outst + {7'h00, o_hs} - {7'h00, c.done};
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) st_r <= '0;
    else st_r <= st_nxt;
  end

  property p_keep_size;
    @(posedge clk) disable iff (!arst_n) (c.valid && c.ready) |=> (o_size == $past(c.size)) && o_valid;
  endproperty
  a_keep_size: assert property (p_keep_size)
    else $error("Piece size differs from command size");

  property p_split_alone;
    @(posedge clk) disable iff (!arst_n) (c.valid && c.ready && c.len > MAXLEN) |-> st_r.outst == 8'h00;
  endproperty
  a_split_alone: assert property (p_split_alone)
    else $error("Splitting command taken with others outstanding");
endmodule : aet_split
`default_nettype wire

/* File: design/aet_switch.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aet_cfg.svh"
module aet_switch #(
  parameter int          AW     = 32,
  parameter int          IW     = 4,
  parameter int          DW     = 32,
  parameter int          MAXOUT = 4,
  parameter logic [AW-1:0] L_BASE = AW'(32'h4000_0000),
  parameter logic [AW-1:0] L_MASK = AW'(32'hffff_0000),
  parameter logic [AW-1:0] T_BASE = AW'(32'h8000_0000),
  parameter logic [AW-1:0] T_MASK = AW'(32'hf000_0000),
  parameter logic [1:0]  L_ACC  = 2'h3,  // {read ok, write ok}
  parameter logic [1:0]  T_ACC  = 2'h3,
  parameter logic        L_SEC  = 1'b0,  // mi_secure_slot of lite port
  parameter logic        T_SEC  = 1'b0   // mi_secure_slot of AXI3 port
) (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            range_check_enable,
  input  wire logic [IW-1:0]   u_awid,
  input  wire logic [AW-1:0]   u_awaddr,
  input  wire logic [7:0]      u_awlen,
  input  wire logic [2:0]      u_awsize,
  input  wire logic [1:0]      u_awburst,
  input  wire logic [2:0]      u_awprot,
  input  wire logic            u_awvalid,
  output logic                 u_awready,
  input  wire logic [DW-1:0]   u_wdata,
  input  wire logic [DW/8-1:0] u_wstrb,
  input  wire logic            u_wlast,
  input  wire logic            u_wvalid,
  output logic                 u_wready,
  output logic [IW-1:0]        u_bid,
  output logic [1:0]           u_bresp,
  output logic                 u_bvalid,
  input  wire logic            u_bready,
  input  wire logic [IW-1:0]   u_arid,
  input  wire logic [AW-1:0]   u_araddr,
  input  wire logic [7:0]      u_arlen,
  input  wire logic [2:0]      u_arsize,
  input  wire logic [1:0]      u_arburst,
  input  wire logic [2:0]      u_arprot,
  input  wire logic            u_arvalid,
  output logic                 u_arready,
  output logic [IW-1:0]        u_rid,
  output logic [DW-1:0]        u_rdata,
  output logic [1:0]           u_rresp,
  output logic                 u_rlast,
  output logic                 u_rvalid,
  input  wire logic            u_rready,
  output logic [AW-1:0]        l_awaddr,
  output logic                 l_awvalid,
  input  wire logic            l_awready,
  output logic [DW-1:0]        l_wdata,
  output logic [DW/8-1:0]      l_wstrb,
  output logic                 l_wvalid,
  input  wire logic            l_wready,
  input  wire logic [1:0]      l_bresp,
  input  wire logic            l_bvalid,
  output logic                 l_bready,
  output logic [AW-1:0]        l_araddr,
  output logic                 l_arvalid,
  input  wire logic            l_arready,
  input  wire logic [DW-1:0]   l_rdata,
  input  wire logic [1:0]      l_rresp,
  input  wire logic            l_rvalid,
  output logic                 l_rready,
  output logic [IW-1:0]        t_awid,
  output logic [AW-1:0]        t_awaddr,
  output logic [3:0]           t_awlen,
  output logic [2:0]           t_awsize,
  output logic [1:0]           t_awburst,
  output logic                 t_awvalid,
  input  wire logic            t_awready,
  output logic [DW-1:0]        t_wdata,
  output logic [DW/8-1:0]      t_wstrb,
  output logic                 t_wlast,
  output logic                 t_wvalid,
  input  wire logic            t_wready,
  input  wire logic [IW-1:0]   t_bid,
  input  wire logic [1:0]      t_bresp,
  input  wire logic            t_bvalid,
  output logic                 t_bready,
  output logic [IW-1:0]        t_arid,
  output logic [AW-1:0]        t_araddr,
  output logic [3:0]           t_arlen,
  output logic [2:0]           t_arsize,
  output logic [1:0]           t_arburst,
  output logic                 t_arvalid,
  input  wire logic            t_arready,
  input  wire logic [IW-1:0]   t_rid,
  input  wire logic [DW-1:0]   t_rdata,
  input  wire logic [1:0]      t_rresp,
  input  wire logic            t_rlast,
  input  wire logic            t_rvalid,
  output logic                 t_rready
);
  if (DW != 32 || IW < 1 || AW < 16) begin : g_chk
    $error("Lite path needs DW 32, IW 1 or more, AW 16 or more");
  end

  typedef struct packed {
    logic              rce1;
    logic              rce2;
    aet_pkg::aet_wst_e wst;
    aet_pkg::aet_tgt_e wtg;
    logic [IW-1:0]     wid;
    logic [AW-1:0]     waddr;
    logic [7:0]        wlen;
    logic [2:0]        wsize;
    logic [1:0]        wburst;
    logic [7:0]        wbeat;
    logic [3:0]        bcnt;
    logic [1:0]        bresp;
    aet_pkg::aet_rst_e rdst;
    aet_pkg::aet_tgt_e rtg;
    logic [IW-1:0]     rid;
    logic [AW-1:0]     raddr;
    logic [7:0]        rlen;
    logic [2:0]        rsize;
    logic [1:0]        rburst;
    logic [7:0]        rbeat;
    logic              lwr;  // Lite stage last granted to a write
  } aet_main_s;

  aet_main_s         st_r, st_nxt;
  aet_pkg::aet_tgt_e aw_tg, ar_tg;
  logic              chk_en, lite_free, w_want, r_want, w_hs, tb_hs, ur_hs;
  logic              w_dat, w_lite, w_a3, r_dat, r_lite, r_a3, r_trap;

  // Target decode with trapping of bad, lite-illegal and non-secure accesses
  function automatic aet_pkg::aet_tgt_e f_route(input logic en, input logic [AW-1:0] a, input logic wr,
                                                input logic [7:0] len, input logic [2:0] sz, input logic [2:0] prot);
    logic hl, ht, ns;
    hl = ((a & L_MASK) == L_BASE) && (wr ? L_ACC[0] : L_ACC[1]);
    ht = ((a & T_MASK) == T_BASE) && (wr ? T_ACC[0] : T_ACC[1]);
    ns = prot[`AET_PROT_NS_BIT];
    if (!en) begin
      f_route = hl ? aet_pkg::TG_LITE : aet_pkg::TG_A3;
    end else if (hl) begin
      f_route = (len != 8'h00 || sz > `AET_LITE_MAX_SIZE || (L_SEC && ns)) ?
                aet_pkg::TG_TRAP : aet_pkg::TG_LITE;
    end else if (ht) begin
      f_route = (T_SEC && ns) ? aet_pkg::TG_TRAP : aet_pkg::TG_A3;
    end else begin
      f_route = aet_pkg::TG_TRAP;
    end
  endfunction : f_route

  // Checking is forced on while any port is secure
  assign chk_en = st_r.rce2 | L_SEC | T_SEC;
  assign aw_tg  = f_route(chk_en, u_awaddr, 1'b1, u_awlen, u_awsize, u_awprot);
  assign ar_tg  = f_route(chk_en, u_araddr, 1'b0, u_arlen, u_arsize, u_arprot);

  // Lite stage owner: one transaction at a time, round robin on a tie
  assign lite_free = !(st_r.wst != aet_pkg::WS_IDLE && st_r.wtg == aet_pkg::TG_LITE) &&
                     !(st_r.rdst != aet_pkg::RS_IDLE && st_r.rtg == aet_pkg::TG_LITE);
  assign w_want    = u_awvalid && st_r.wst == aet_pkg::WS_IDLE && aw_tg == aet_pkg::TG_LITE;
  assign r_want    = u_arvalid && st_r.rdst == aet_pkg::RS_IDLE && ar_tg == aet_pkg::TG_LITE;
  assign u_awready = st_r.wst == aet_pkg::WS_IDLE &&
                     (aw_tg != aet_pkg::TG_LITE || (lite_free && (!r_want || !st_r.lwr)));
  assign u_arready = st_r.rdst == aet_pkg::RS_IDLE &&
                     (ar_tg != aet_pkg::TG_LITE || (lite_free && (!w_want || st_r.lwr)));

  // Write channel steering, only after its address was taken
  assign w_dat    = st_r.wst == aet_pkg::WS_DATA;
  assign w_lite   = st_r.wtg == aet_pkg::TG_LITE;
  assign w_a3     = st_r.wtg == aet_pkg::TG_A3;
  assign u_wready = w_dat && (w_lite ? l_wready : w_a3 ? t_wready : 1'b1);
  assign w_hs     = u_wvalid && u_wready;
  assign l_wvalid = w_dat && w_lite && u_wvalid;
  assign l_wdata  = u_wdata;
  assign l_wstrb  = u_wstrb;
  assign t_wvalid = w_dat && w_a3 && u_wvalid;
  assign t_wdata  = u_wdata;
  assign t_wstrb  = u_wstrb;
  assign t_wlast  = u_wlast || st_r.wbeat[3:0] == 4'hf;
  assign l_bready = st_r.wst == aet_pkg::WS_RESP && w_lite;
  assign t_bready = st_r.wst == aet_pkg::WS_RESP && w_a3 && t_bid == st_r.wid;
  assign tb_hs    = t_bvalid && t_bready;
  assign u_bvalid = st_r.wst == aet_pkg::WS_BOUT;
  assign u_bid    = st_r.wid;
  assign u_bresp  = st_r.bresp;

  // Shared lite address bus, copied onto both address outputs
  assign l_awaddr  = st_r.lwr ? st_r.waddr : st_r.raddr;
  assign l_araddr  = l_awaddr;
  assign l_awvalid = st_r.wst == aet_pkg::WS_ADDR && w_lite;
  assign l_arvalid = st_r.rdst == aet_pkg::RS_ADDR && r_lite;

  // Read channel steering; trapped reads answered locally
  assign r_dat    = st_r.rdst == aet_pkg::RS_DATA;
  assign r_lite   = st_r.rtg == aet_pkg::TG_LITE;
  assign r_a3     = st_r.rtg == aet_pkg::TG_A3;
  assign r_trap   = st_r.rtg == aet_pkg::TG_TRAP;
  assign l_rready = r_dat && r_lite && u_rready;
  assign t_rready = r_dat && r_a3 && u_rready && t_rid == st_r.rid;
  assign u_rvalid = r_dat && (r_lite ? l_rvalid : r_a3 ? (t_rvalid && t_rid == st_r.rid) : 1'b1);
  assign u_rid    = st_r.rid;
  assign u_rdata  = r_lite ? l_rdata : r_a3 ? t_rdata : '0;
  assign u_rresp  = r_lite ? l_rresp : r_a3 ? t_rresp : `AET_RESP_DECERR;
  assign u_rlast  = r_lite || st_r.rbeat == st_r.rlen;
  assign ur_hs    = u_rvalid && u_rready;

  // Commands for the AXI3 stage
  aet_cmd_if #(.AW(AW), .IW(IW)) cw ();
  aet_cmd_if #(.AW(AW), .IW(IW)) cr ();
  assign cw.id    = st_r.wid;
  assign cw.addr  = st_r.waddr;
  assign cw.len   = st_r.wlen;
  assign cw.size  = st_r.wsize;
  assign cw.burst = st_r.wburst;
  assign cw.valid = st_r.wst == aet_pkg::WS_ADDR && w_a3;
  assign cw.done  = tb_hs;
  assign cr.id    = st_r.rid;
  assign cr.addr  = st_r.raddr;
  assign cr.len   = st_r.rlen;
  assign cr.size  = st_r.rsize;
  assign cr.burst = st_r.rburst;
  assign cr.valid = st_r.rdst == aet_pkg::RS_ADDR && r_a3;
  assign cr.done  = t_rvalid && t_rready && t_rlast;

  // AXI3 conversion stage, one per direction
  aet_split #(.AW(AW), .IW(IW), .MAXOUT(MAXOUT)) u_split_w (
    .clk(clk), .arst_n(arst_n), .c(cw), .o_id(t_awid), .o_addr(t_awaddr), .o_len(t_awlen),
    .o_size(t_awsize), .o_burst(t_awburst), .o_valid(t_awvalid), .o_ready(t_awready));
  aet_split #(.AW(AW), .IW(IW), .MAXOUT(MAXOUT)) u_split_r (
    .clk(clk), .arst_n(arst_n), .c(cr), .o_id(t_arid), .o_addr(t_araddr), .o_len(t_arlen),
    .o_size(t_arsize), .o_burst(t_arburst), .o_valid(t_arvalid), .o_ready(t_arready));

  // Next state of both paths; no general protocol checks here
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rce1 = range_check_enable;
    st_nxt.rce2 = st_r.rce1;
    case (st_r.wst)
      aet_pkg::WS_IDLE: begin
        if (u_awvalid && u_awready) begin
          st_nxt.wtg    = aw_tg;
          st_nxt.wid    = u_awid;
          st_nxt.waddr  = u_awaddr;
          st_nxt.wlen   = u_awlen;
          st_nxt.wsize  = u_awsize;
          st_nxt.wburst = u_awburst;
          st_nxt.wbeat  = 8'h00;
          st_nxt.bcnt   = 4'h0;
          st_nxt.bresp  = `AET_RESP_OKAY;
          st_nxt.wst    = (aw_tg == aet_pkg::TG_TRAP) ? aet_pkg::WS_DATA : aet_pkg::WS_ADDR;
          if (aw_tg == aet_pkg::TG_LITE) st_nxt.lwr = 1'b1;
        end
      end
      aet_pkg::WS_ADDR: begin
        if ((w_lite && l_awready) || (w_a3 && cw.ready)) st_nxt.wst = aet_pkg::WS_DATA;
      end
      aet_pkg::WS_DATA: begin
        if (w_hs) begin
          st_nxt.wbeat = st_r.wbeat + 8'h01;
          if (u_wlast || w_lite) begin
            st_nxt.wst = w_lite || w_a3 ? aet_pkg::WS_RESP : aet_pkg::WS_BOUT;
            if (!w_lite && !w_a3) st_nxt.bresp = `AET_RESP_DECERR;
          end
        end
      end
      aet_pkg::WS_RESP: begin
        if (w_lite) begin
          if (l_bvalid) begin
            st_nxt.bresp = l_bresp;
            st_nxt.wst   = aet_pkg::WS_BOUT;
          end
        end else if (tb_hs) begin
          st_nxt.bcnt = st_r.bcnt + 4'h1;
          if (t_bresp > st_r.bresp) st_nxt.bresp = t_bresp;
          if (st_r.bcnt == st_r.wlen[7:4]) st_nxt.wst = aet_pkg::WS_BOUT;
        end
      end
      aet_pkg::WS_BOUT: begin
        if (u_bready) st_nxt.wst = aet_pkg::WS_IDLE;
      end
      default: st_nxt.wst = aet_pkg::WS_IDLE;
    endcase
    case (st_r.rdst)
      aet_pkg::RS_IDLE: begin
        if (u_arvalid && u_arready) begin
          st_nxt.rtg    = ar_tg;
          st_nxt.rid    = u_arid;
          st_nxt.raddr  = u_araddr;
          st_nxt.rlen   = u_arlen;
          st_nxt.rsize  = u_arsize;
          st_nxt.rburst = u_arburst;
          st_nxt.rbeat  = 8'h00;
          st_nxt.rdst   = (ar_tg == aet_pkg::TG_TRAP) ? aet_pkg::RS_DATA : aet_pkg::RS_ADDR;
          if (ar_tg == aet_pkg::TG_LITE) st_nxt.lwr = 1'b0;
        end
      end
      aet_pkg::RS_ADDR: begin
        if ((r_lite && l_arready) || (r_a3 && cr.ready)) st_nxt.rdst = aet_pkg::RS_DATA;
      end
      aet_pkg::RS_DATA: begin
        if (ur_hs) begin
          st_nxt.rbeat = st_r.rbeat + 8'h01;
          if (u_rlast) st_nxt.rdst = aet_pkg::RS_IDLE;
        end
      end
      default: st_nxt.rdst = aet_pkg::RS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) st_r <= '0;
    else st_r <= st_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_trap_quiet;
    (st_r.wtg == aet_pkg::TG_TRAP && st_r.wst != aet_pkg::WS_IDLE) |-> !l_awvalid && !t_awvalid && !l_wvalid && !t_wvalid;
  endproperty
  a_trap_quiet: assert property (p_trap_quiet)
    else $error("Trapped write reached a downstream port");

  property p_lite_len;
    (u_awvalid && u_awready && chk_en && L_ACC[0] && (u_awaddr & L_MASK) == L_BASE && u_awlen != 8'h00)
      |=> st_r.wtg == aet_pkg::TG_TRAP && st_r.wst == aet_pkg::WS_DATA;
  endproperty
  a_lite_len: assert property (p_lite_len)
    else $error("Lite burst not trapped");

  property p_lite_size;
    (u_arvalid && u_arready && chk_en && L_ACC[1] && (u_araddr & L_MASK) == L_BASE && u_arsize > `AET_LITE_MAX_SIZE)
      |=> st_r.rtg == aet_pkg::TG_TRAP ##0 u_rvalid;
  endproperty
  a_lite_size: assert property (p_lite_size)
    else $error("Wide lite access not trapped");

  property p_no_check;
    (u_awvalid && u_awready && !chk_en) |=> st_r.wtg != aet_pkg::TG_TRAP;
  endproperty
  a_no_check: assert property (p_no_check)
    else $error("Trap taken with checking off");

  property p_one_lite;
    !((l_awvalid || l_wvalid || l_bready) && (l_arvalid || l_rready));
  endproperty
  a_one_lite: assert property (p_one_lite)
    else $error("Lite stage running two transactions");

  property p_addr_copy;
    l_awvalid |-> l_araddr == st_r.waddr;
  endproperty
  a_addr_copy: assert property (p_addr_copy)
    else $error("Lite address copies disagree");

  property p_id_block;
    (t_bvalid && t_bid != st_r.wid) |-> !t_bready;
  endproperty
  a_id_block: assert property (p_id_block)
    else $error("Ready given to unknown response ID");

  property p_trap_read;
    (u_rvalid && r_trap) |-> u_rresp == `AET_RESP_DECERR && u_rlast == (st_r.rbeat == st_r.rlen);
  endproperty
  a_trap_read: assert property (p_trap_read)
    else $error("Trapped read beat wrong");

  property p_trap_write;
    ($rose(u_bvalid) && st_r.wtg == aet_pkg::TG_TRAP) |-> u_bresp == `AET_RESP_DECERR && $past(w_hs && u_wlast);
  endproperty
  a_trap_write: assert property (p_trap_write)
    else $error("Trapped write answered early or wrongly");
endmodule : aet_switch
`default_nettype wire

/* File: testbench/aet_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Lite slave and AXI3 slave behind the block's downstream ports
module aet_far_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        stall,
  input  wire logic [3:0]  l_req,
  input  wire logic [31:0] l_addr,
  input  wire logic [4:0]  t_req,
  input  wire logic [3:0]  aw_id,
  input  wire logic [3:0]  ar_id,
  input  wire logic [3:0]  ar_len,
  output logic             rdy,
  output logic      [1:0]  resp,
  output logic      [1:0]  l_ack,
  output logic      [31:0] rdata,
  output logic             rv,
  output logic             rl,
  output logic             bv,
  output logic      [3:0]  b_id,
  output logic      [3:0]  r_id
);
  logic [3:0] q[$];
  logic [3:0] cnt;
  logic [2:0] nb;  // Write answers owed, one per piece
  // Readies drop while the bench stalls
  assign rdy  = ~stall;
  assign resp = 2'h0;
  assign rl   = rv && cnt == 4'h0;
  assign bv   = nb != 3'h0;
  // Answers one cycle after a request; released data reads inverted
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q.delete();
      l_ack <= 2'h0;
      {rv, nb, cnt, b_id, r_id} <= '0;
      rdata <= 32'h0;
    end else begin
      l_ack[1] <= (l_req[3] & rdy) | (l_ack[1] & ~l_req[2]);
      l_ack[0] <= (l_req[1] & rdy) | (l_ack[0] & ~l_req[0]);
      // Every last data beat of a piece owes its own answer
      nb <= nb + {2'h0, t_req[2] & rdy} - {2'h0, bv & t_req[1]};
      if (t_req[0] && rdy)
        b_id <= aw_id;
      if (t_req[4] && rdy) begin
        q.push_back(ar_len);
        r_id <= ar_id;
      end
      if (l_req[1] && rdy)
        rdata <= l_addr;
      else if (!(l_ack[0] & ~l_req[0]) && !(rv & ~t_req[3]))
        rdata <= ~rdata;
      // Each queued piece gives len+1 beats, last one marked
      if (rv && t_req[3]) begin
        rv  <= cnt != 4'h0;
        cnt <= cnt - 4'h1;
      end
      if ((!rv || (t_req[3] && cnt == 4'h0)) && q.size() > 0) begin
        cnt <= q.pop_front();
        rv  <= 1'b1;
      end
    end
  end
endmodule : aet_far_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "aet_cfg.svh"
module testbench;
  logic clk, arst_n, range_check_enable, stall;
  logic [3:0] u_awid, u_arid, u_bid, u_rid, t_awid, t_bid, t_arid, t_rid, t_awlen, t_arlen, rid, ar_len_seen;
  logic [31:0] u_awaddr, u_araddr, u_wdata, u_rdata, l_awaddr, l_wdata, l_araddr, l_rdata, rd_d;
  logic [31:0] t_awaddr, t_wdata, t_araddr, t_rdata, ar_addr_seen;
  logic [7:0] u_awlen, u_arlen;
  logic [2:0] u_awsize, u_awprot, u_arsize, u_arprot, t_awsize, t_arsize, ar_size_seen;
  logic [1:0] u_awburst, u_arburst, u_bresp, u_rresp, l_bresp, l_rresp, t_awburst, t_arburst, t_bresp, t_rresp, rs;
  logic [3:0] u_wstrb, l_wstrb, t_wstrb;
  logic u_awvalid, u_awready, u_wlast, u_wvalid, u_wready, u_bvalid, u_bready, u_arvalid, u_arready;
  logic u_rlast, u_rvalid, u_rready, l_awvalid, l_awready, l_wvalid, l_wready, l_bvalid, l_bready;
  logic l_arvalid, l_arready, l_rvalid, l_rready, t_awvalid, t_awready, t_wlast, t_wvalid, t_wready;
  logic t_bvalid, t_bready, t_arvalid, t_arready, t_rlast, t_rvalid, t_rready;
  int errors, n_tests, cyc, n_ar, n_lw, beats;

  aet_switch dut (.*);
  aet_far_model far (.clk(clk), .arst_n(arst_n), .stall(stall), .l_req({l_wvalid, l_bready, l_arvalid, l_rready}),
    .l_addr(l_araddr), .t_req({t_arvalid, t_rready, t_wvalid & t_wlast, t_bready, t_awvalid}), .aw_id(t_awid),
    .ar_id(t_arid), .ar_len(t_arlen), .rdy(l_awready), .resp(l_bresp), .l_ack({l_bvalid, l_rvalid}),
    .rdata(l_rdata), .rv(t_rvalid), .rl(t_rlast), .bv(t_bvalid), .b_id(t_bid), .r_id(t_rid));
  assign {l_wready, l_arready, t_awready, t_wready, t_arready} = {5{l_awready}};
  assign {l_rresp, t_bresp, t_rresp} = {3{l_bresp}};
  assign t_rdata = l_rdata;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard and downstream command monitor
  always @(negedge clk) begin
    cyc++;
    n_lw += int'(l_awvalid && l_awready);
    if (t_arvalid && t_arready) begin
      n_ar++;
      {ar_len_seen, ar_size_seen, ar_addr_seen} = {t_arlen, t_arsize, t_araddr};
    end
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One read; keeps the last beat and the beat count
  task automatic rd(input logic [31:0] a, input logic [7:0] n, input logic [2:0] sz, input logic [3:0] id);
    logic last;
    {u_araddr, u_arlen, u_arsize, u_arid, u_arvalid} <= {a, n, sz, id, 1'b1};
    do @(negedge clk); while (u_arready !== 1'b1);
    @(posedge clk);
    u_arvalid <= 1'b0;
    beats = 0;
    do begin
      do @(negedge clk); while (u_rvalid !== 1'b1);
      beats++;
      {rs, rid, rd_d, last} = {u_rresp, u_rid, u_rdata, u_rlast};
      @(posedge clk);
    end while (last !== 1'b1);
  endtask : rd

  // One write of n+1 beats, then its response
  task automatic wr(input logic [31:0] a, input logic [7:0] n, input logic [2:0] sz, input logic [3:0] id);
    {u_awaddr, u_awlen, u_awsize, u_awid, u_awvalid} <= {a, n, sz, id, 1'b1};
    do @(negedge clk); while (u_awready !== 1'b1);
    @(posedge clk);
    u_awvalid <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      {u_wvalid, u_wlast, u_wdata} <= {1'b1, i == n, 32'(i)};
      do @(negedge clk); while (u_wready !== 1'b1);
      @(posedge clk);
    end
    u_wvalid <= 1'b0;
    do @(negedge clk); while (u_bvalid !== 1'b1);
    {rs, rid} = {u_bresp, u_bid};
    @(posedge clk);
  endtask : wr

  // Unmapped read gets every beat as a decode error
  task automatic trap_rd;
    rd(32'h1000_0000, 8'h02, 3'h2, 4'h5);
    chk(32'(beats), 32'h3);
    chk(rs, `AET_RESP_DECERR);
    chk(rid, 4'h5);
    chk(rd_d, 32'h0);
  endtask : trap_rd

  // Single lite read against a slow slave
  task automatic lite_rd;
    stall <= 1'b1;
    fork
      rd(32'h4000_0010, 8'h00, 3'h2, 4'h9);
      begin
        repeat (4) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(rd_d, 32'h4000_0010);
    chk(rid, 4'h9);
    chk(l_awaddr, 32'h4000_0010);
    chk(rs, `AET_RESP_OKAY);
    wr(32'h4000_0004, 8'h00, 3'h2, 4'h4);
    chk({rs, rid}, {2'h0, 4'h4});
    chk(l_araddr, 32'h4000_0004);
  endtask : lite_rd

  // Lite burst and wide lite access are trapped, never forwarded
  task automatic lite_bad;
    int k;
    k = n_lw;
    wr(32'h4000_0020, 8'h01, 3'h2, 4'h3);
    chk(rs, `AET_RESP_DECERR);
    chk(rid, 4'h3);
    chk(32'(n_lw - k), 32'h0);
    rd(32'h4000_0000, 8'h00, 3'h3, 4'h1);
    chk(rs, `AET_RESP_DECERR);
  endtask : lite_bad

  // Twenty-beat read and 32-beat write cross to the AXI3 port in pieces
  task automatic a3_split;
    int k;
    k = n_ar;
    rd(32'h8000_0100, 8'd19, 3'h1, 4'h6);
    chk(32'(beats), 32'd20);
    chk(32'(n_ar - k), 32'h2);
    chk(ar_len_seen, 4'h3);
    chk(ar_size_seen, 3'h1);
    chk(ar_addr_seen, 32'h8000_0120);
    chk(rid, 4'h6);
    wr(32'h8000_0000, 8'd31, 3'h2, 4'h7);
    chk({rs, rid}, {2'h0, 4'h7});
  endtask : a3_split

  // With checking off an unmapped read passes straight through
  task automatic no_check;
    int k;
    range_check_enable <= 1'b0;
    repeat (3) @(posedge clk);
    k = n_ar;
    rd(32'h1000_0000, 8'h00, 3'h2, 4'h2);
    chk(rs, `AET_RESP_OKAY);
    chk(32'(n_ar - k), 32'h1);
  endtask : no_check

  task automatic results;
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    {arst_n, stall, range_check_enable, u_bready, u_rready} = 5'b00111;
    {u_awvalid, u_wvalid, u_arvalid, u_wlast, u_awprot, u_arprot} = '0;
    {u_awaddr, u_araddr, u_wdata, u_awid, u_arid, u_awlen, u_arlen, u_awsize, u_arsize} = '0;
    {u_awburst, u_arburst, u_wstrb} = {`AET_BURST_INCR, `AET_BURST_INCR, 4'hf};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    trap_rd();
    lite_rd();
    lite_bad();
    a3_split();
    no_check();
    results();
  end
endmodule : testbench
`default_nettype wire
